// ===== rtl/gstmr_pkg.sv
package gstmr_pkg;
  // Register map, byte wide registers
  localparam logic [2:0] GSTMR_ADDR_LOW = 3'h0;
  localparam logic [2:0] GSTMR_ADDR_HIGH = 3'h1;
  localparam logic [2:0] GSTMR_ADDR_CTRL = 3'h2;
  localparam logic [2:0] GSTMR_ADDR_GATE = 3'h3;
  localparam logic [2:0] GSTMR_ADDR_CLK = 3'h4;
  localparam logic [2:0] GSTMR_ADDR_FLAG = 3'h5;
  // Control register fields
  localparam int GSTMR_CTRL_ON = 0;
  localparam int GSTMR_CTRL_WIDE = 1;
  localparam int GSTMR_CTRL_NOSYNC = 2;
  localparam int GSTMR_CTRL_PS_LO = 4;
  // Gate and flag register fields
  localparam int GSTMR_GATE_SEL_LO = 0;
  localparam int GSTMR_GATE_POL = 6;
  localparam int GSTMR_GATE_ON = 7;
  localparam int GSTMR_FLAG_OVF = 0;
  // Clock source codes, defaults only
  localparam logic [1:0] GSTMR_CS_INSTR = 2'h0;
  localparam logic [1:0] GSTMR_CS_OSC = 2'h1;
  localparam logic [1:0] GSTMR_CS_EXT = 2'h2;
  // Fosc is four mclk cycles per instruction cycle
  localparam logic [1:0] GSTMR_INSTR_DIV_LAST = 2'h3;
  localparam logic [15:0] GSTMR_OSC_STEP = 16'h0004;
  localparam logic [15:0] GSTMR_ONE_STEP = 16'h0001;
  localparam logic [15:0] GSTMR_COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] GSTMR_BYTE_ZERO = 8'h00;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gstmr_bus_t;

  typedef struct packed {
    logic on;
    logic wide;
    logic nosync;
    logic [1:0] ps;
    logic gating_on;
    logic gate_polarity;
    logic [1:0] gate_source_select;
    logic [1:0] clk_src;
  } gstmr_cfg_t;
endpackage

// ===== rtl/gstmr_edge.sv
// Rising edge finder on the external clock with falling-edge arming
module gstmr_edge
  import gstmr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ext_in,
  input wire logic nosync,
  input wire logic disarm,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic armed;
  } gstmr_edge_t;
  gstmr_edge_t st, next_st;
  logic lvl;

  // Synchronised path or direct path; nosync skips the two stages
  always_comb begin
    lvl = nosync ? ext_in : st.s2;
    next_st = st;
    next_st.s1 = ext_in;
    next_st.s2 = st.s1;
    next_st.prev = lvl;
    rise = st.armed && lvl && !st.prev;
    // A falling edge arms the first count after any disarm
    if (disarm) begin
      next_st.armed = 1'b0;
    end else if (!lvl && st.prev) begin
      next_st.armed = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_arm_needs_fall: assert property (@(posedge mclk)
    disable iff (!rst_n) $past(disarm) |-> !rise)
    else $error("rise after disarm");
endmodule // gstmr_edge

// ===== rtl/gstmr_presc.sv
// Two-bit prescaler, 1/2/4/8 of the input tick
module gstmr_presc
  import gstmr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick_in,
  input wire logic [1:0] ps,
  input wire logic clear,
  output logic tick_out
);
  typedef struct packed {
    logic [2:0] cnt;
  } gstmr_presc_t;
  gstmr_presc_t st, next_st;
  logic [2:0] mask;

  // Output when the low ps bits of the counter are all ones
  always_comb begin
    mask = 3'(({1'b0, 2'h0} | 3'h7) >> (2'h3 - ps));
    next_st = st;
    tick_out = tick_in && ((st.cnt & mask) == mask);
    if (clear) begin
      next_st.cnt = 3'h0;
    end else if (tick_in) begin
      next_st.cnt = 3'(st.cnt + 3'h1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_div_one_pass: assert property (@(posedge mclk)
    disable iff (!rst_n) (ps == 2'h0 && tick_in && !clear) |-> tick_out)
    else $error("1:1 prescale dropped a tick");
endmodule // gstmr_presc

// ===== rtl/gstmr_top.sv
// What this block does
// - Counter runs only when on; gating_on chooses gated or free counting.
// - Sixteen bit up counter in two bytes; writes load it at once, except wide-mode high writes, which go to the buffer.
// - Instruction clock adds one per cycle; oscillator clock adds four.
// - Counter mode needs a falling edge before the first counted rise.
// - External source counts rising edges, synchronised or not.
// - Prescale 1,2,4,8; hidden counter cleared only by low byte write.
// - Sync-disable bit counts the external clock without synchronising.
// - Async external counting keeps running in sleep and flags overflow.
// - Switching sync mode may lose or add one increment.
// - Byte reads during async counting always return valid bytes.
// - In wide mode the high byte is reached only through its buffer.
// - Wide mode low byte read copies live high byte into buffer.
// - Wide mode low write loads buffer and low byte together.
// - Gated counting runs when gate equals polarity bit.
// - Inactive gate holds the count unchanged.
// - Gate source chosen by select field, polarity applied to each source before.
// - Rollover from maximum to zero sets the overflow flag.
// - Sync-disable bit ignored for instruction and oscillator clocks.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
module gstmr_top
  import gstmr_pkg::*;
#(
  parameter logic [1:0] CS_INSTR = GSTMR_CS_INSTR,
  parameter logic [1:0] CS_OSC = GSTMR_CS_OSC,
  parameter logic [1:0] CS_EXT = GSTMR_CS_EXT,
  parameter int GATE_SRCS = 4
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic external_clock_input,
  input wire logic [GATE_SRCS-1:0] gate_input,
  input wire logic sleep,
  output logic overflow_flag,
  output logic [15:0] count
);
  typedef struct packed {
    gstmr_cfg_t cfg;
    logic [15:0] cnt;
    logic [7:0] hbuf;
    logic ovf;
    logic [1:0] idiv;
    logic [7:0] rdata;
  } gstmr_state_t;
  gstmr_state_t st, next_st;
  gstmr_bus_t bus;
  logic instr_tick, ext_rise, src_tick, pre_tick, gate_lvl, run;
  logic disarm, presc_clr, is_ext, is_int;
  logic [GATE_SRCS-1:0] gate_match;
  logic [15:0] step, sum;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Register decode used for the write-side strobes disarm and presc_clr
  function automatic logic hit(input gstmr_bus_t b, input logic [2:0] a);
    return b.addr == a;
  endfunction

  // Gate: each source meets the polarity, then the select picks one
  for (genvar gi = 0; gi < GATE_SRCS; gi++) begin : g_gate_cmp
    assign gate_match[gi] = gate_input[gi] == st.cfg.gate_polarity;
  end
  assign gate_lvl = gate_match[st.cfg.gate_source_select];
  assign run = st.cfg.on && (!st.cfg.gating_on || gate_lvl);

  // Clock source; sync-disable only meaningful for the pin
  assign is_ext = st.cfg.clk_src == CS_EXT;
  // The spare code selects no source, so the count rests there
  assign is_int = st.cfg.clk_src == CS_INSTR || st.cfg.clk_src == CS_OSC;
  assign instr_tick = st.idiv == GSTMR_INSTR_DIV_LAST;
  // Sleep halts the instruction clock; only the pin path keeps going
  assign src_tick = is_ext ? ext_rise :
    (is_int && !sleep && instr_tick);
  // Any count write or stop makes the pin show a fall again first
  assign disarm = !st.cfg.on || (bus.wr && (hit(bus, GSTMR_ADDR_LOW) ||
    hit(bus, GSTMR_ADDR_HIGH)));
  // A high byte write keeps the prescaler phase
  assign presc_clr = bus.wr && hit(bus, GSTMR_ADDR_LOW);

  gstmr_edge u_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .ext_in(external_clock_input),
    .nosync(st.cfg.nosync && is_ext),
    .disarm(disarm),
    .rise(ext_rise)
  );

  gstmr_presc u_presc (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick_in(src_tick && run),
    .ps(st.cfg.ps),
    .clear(presc_clr),
    .tick_out(pre_tick)
  );

  // Oscillator source adds four, low two bits then imprecise
  assign step = (st.cfg.clk_src == CS_OSC) ? GSTMR_OSC_STEP :
    GSTMR_ONE_STEP;
  assign sum = 16'(st.cnt + step);

  // Next state: counting, a write wins over the increment in the bytes it loads
  always_comb begin
    next_st = st;
    next_st.idiv = 2'(st.idiv + 2'h1);
    if (pre_tick) begin
      next_st.cnt = sum;
      if (sum < st.cnt) begin
        next_st.ovf = 1'b1;
      end
    end
    if (bus.wr) begin
      unique case (bus.addr)
        GSTMR_ADDR_LOW: begin
          // Wide mode loads both bytes at once, high byte from the buffer
          if (st.cfg.wide) begin
            next_st.cnt = {st.hbuf, bus.wdata};
          end else begin
            next_st.cnt = {next_st.cnt[15:8], bus.wdata};
          end
        end
        GSTMR_ADDR_HIGH: begin
          if (st.cfg.wide) begin
            next_st.hbuf = bus.wdata;
          end else begin
            next_st.cnt = {bus.wdata, next_st.cnt[7:0]};
          end
        end
        // A control write leaves the prescaler phase alone
        GSTMR_ADDR_CTRL: begin
          next_st.cfg.on = bus.wdata[GSTMR_CTRL_ON];
          next_st.cfg.wide = bus.wdata[GSTMR_CTRL_WIDE];
          next_st.cfg.nosync = bus.wdata[GSTMR_CTRL_NOSYNC];
          next_st.cfg.ps = bus.wdata[GSTMR_CTRL_PS_LO +: 2];
        end
        GSTMR_ADDR_GATE: begin
          next_st.cfg.gating_on = bus.wdata[GSTMR_GATE_ON];
          next_st.cfg.gate_polarity = bus.wdata[GSTMR_GATE_POL];
          next_st.cfg.gate_source_select =
            bus.wdata[GSTMR_GATE_SEL_LO +: 2];
        end
        // Source codes are parameters, so no code is refused here
        GSTMR_ADDR_CLK: next_st.cfg.clk_src = bus.wdata[1:0];
        GSTMR_ADDR_FLAG: begin
          // Set wins over a clear in the same cycle
          if (!bus.wdata[GSTMR_FLAG_OVF] && !(pre_tick && sum < st.cnt))
            begin
            next_st.ovf = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Reads: registered, whole byte from one state snapshot
    // Zero between reads, so a stale byte never looks fresh
    next_st.rdata = GSTMR_BYTE_ZERO;
    if (bus.rd) begin
      unique case (bus.addr)
        GSTMR_ADDR_LOW: begin
          next_st.rdata = st.cnt[7:0];
          if (st.cfg.wide) begin
            next_st.hbuf = st.cnt[15:8];
          end
        end
        // Wide mode never shows the live high byte
        GSTMR_ADDR_HIGH: next_st.rdata = st.cfg.wide ? st.hbuf :
          st.cnt[15:8];
        GSTMR_ADDR_CTRL: next_st.rdata = {2'h0, st.cfg.ps, 1'b0,
          st.cfg.nosync, st.cfg.wide, st.cfg.on};
        GSTMR_ADDR_GATE: next_st.rdata = {st.cfg.gating_on,
          st.cfg.gate_polarity, 4'h0, st.cfg.gate_source_select};
        GSTMR_ADDR_CLK: next_st.rdata = {6'h00, st.cfg.clk_src};
        GSTMR_ADDR_FLAG: next_st.rdata = {7'h00, st.ovf};
        default: next_st.rdata = GSTMR_BYTE_ZERO;
      endcase
    end
  end

  // Single register for all state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register
  assign rdata = st.rdata;
  assign overflow_flag = st.ovf;
  assign count = st.cnt;

  // Counting holds whenever the run conditions are not met
  a_off_holds: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!st.cfg.on && !wr) |=> count == $past(count))
    else $error("count moved while off");

  a_gate_holds: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (st.cfg.gating_on && !gate_lvl && !wr) |=> count == $past(count))
    else $error("count moved with gate inactive");

  a_still_count: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!pre_tick && !wr) |=> count == $past(count))
    else $error("count moved without a tick");

  // Byte access, narrow and wide
  a_narrow_low: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (wr && addr == GSTMR_ADDR_LOW && !st.cfg.wide) |=>
    count[7:0] == $past(wdata))
    else $error("low byte write lost");

  a_wide_load: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (wr && addr == GSTMR_ADDR_LOW && st.cfg.wide) |=>
    count == {$past(st.hbuf), $past(wdata)})
    else $error("wide write did not load both bytes");

  a_wide_no_direct: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (wr && addr == GSTMR_ADDR_HIGH && st.cfg.wide && !pre_tick) |=>
    count == $past(count))
    else $error("wide high write reached the count");

  a_wide_snap: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (rd && addr == GSTMR_ADDR_LOW && st.cfg.wide) |=>
    st.hbuf == $past(count[15:8]))
    else $error("high not buffered");

  a_high_buf_read: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (rd && addr == GSTMR_ADDR_HIGH && st.cfg.wide) |=>
    rdata == $past(st.hbuf))
    else $error("high read bypassed buffer");

  a_low_read: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (rd && addr == GSTMR_ADDR_LOW) |=> rdata == $past(count[7:0]))
    else $error("low read not from one snapshot");

  // Overflow flag
  a_roll_flag: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (count == GSTMR_COUNT_MAX && pre_tick && step == GSTMR_ONE_STEP && !wr)
    |=> overflow_flag && count == 16'h0000)
    else $error("rollover missed flag");

  a_flag_sticky: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (overflow_flag && !(wr && addr == GSTMR_ADDR_FLAG)) |=> overflow_flag)
    else $error("flag dropped without a clear");

  a_flag_set_wins: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (wr && addr == GSTMR_ADDR_FLAG && pre_tick && sum < st.cnt) |=>
    overflow_flag)
    else $error("clear beat a same cycle overflow");

  // Clock source rates
  a_osc_four: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (pre_tick && st.cfg.clk_src == CS_OSC && !wr) |=>
    count == 16'($past(count) + GSTMR_OSC_STEP))
    else $error("oscillator step not four");

  a_osc_low_bits: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (st.cfg.clk_src == CS_OSC && !wr) |=> count[1:0] == $past(count[1:0]))
    else $error("oscillator step moved low bits");

  a_instr_rate: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!is_ext && src_tick) |=> !src_tick [*3])
    else $error("instruction tick too often");

  a_sleep_halt: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (sleep && !is_ext) |-> !src_tick)
    else $error("internal clock ran in sleep");

  a_spare_code: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!is_ext && !is_int) |-> !src_tick)
    else $error("spare source code counted");

  // Main scenarios reached
  c_rollover: cover property (@(posedge mclk) disable iff (!rst_n)
    $rose(overflow_flag));

  c_gated_count: cover property (@(posedge mclk) disable iff (!rst_n)
    st.cfg.gating_on && pre_tick);

  c_wide_write: cover property (@(posedge mclk) disable iff (!rst_n)
    wr && addr == GSTMR_ADDR_LOW && st.cfg.wide);

  c_ext_count: cover property (@(posedge mclk) disable iff (!rst_n)
    is_ext && pre_tick);

  c_sleep_count: cover property (@(posedge mclk) disable iff (!rst_n)
    sleep && is_ext && pre_tick);
endmodule // gstmr_top

// ===== sim/gstmr_pin_model.sv
// Far side: external clock pin and the gate sources
module gstmr_pin_model (
  input wire logic mclk,
  output logic ext_clk,
  output logic [3:0] gate
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pin idles low, so the first edge of a burst is a rise
  initial begin
    ext_clk = 1'b0;
    gate = 4'h0;
  end

  // Clock stands still between bursts, as a real pin would
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge mclk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask

  // Unselected sources carry the inverse, so a wrong pick shows
  task automatic set_gate(input int sel, input logic val);
    logic [3:0] g;
    g = {4{~val}};
    g[sel] = val;
    @(posedge mclk);
    gate <= g;
  endtask
endmodule // gstmr_pin_model

// ===== sim/gstmr_tb_top.sv
module gstmr_tb_top
  import gstmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_n, wr, rd, sleep, ext_clk, overflow_flag;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic [3:0] gate;
  logic [15:0] count, d, prev;
  int miscompares = 0;
  int checks_done = 0;

  always #50 mclk = ~mclk;

  gstmr_top i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .external_clock_input(ext_clk),
    .gate_input(gate), .sleep(sleep), .overflow_flag(overflow_flag),
    .count(count));
  gstmr_pin_model i_pin (.mclk(mclk), .ext_clk(ext_clk), .gate(gate));

  task automatic chk(input string name, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input string n, input logic [2:0] a, logic [7:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(n, {8'h00, rdata}, {8'h00, e});
  endtask

  // Window lengths are multiples of the tick, so phase cannot matter
  task automatic delta(input int cyc);
    logic [15:0] c0;
    @(negedge mclk);
    c0 = count;
    repeat (cyc) @(negedge mclk);
    d = count - c0;
  endtask

  task automatic cfg(input logic [7:0] c, g, input logic [1:0] s);
    wr_reg(GSTMR_ADDR_CLK, {6'h00, s});
    wr_reg(GSTMR_ADDR_GATE, g);
    wr_reg(GSTMR_ADDR_CTRL, c);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog, well beyond the roughly 1500 cycles the tests need
  initial begin
    #2000000;
    miscompares++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    {wr, rd, sleep, addr, wdata} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk("low", GSTMR_ADDR_LOW, 8'h00);
    rd_chk("ctrl", GSTMR_ADDR_CTRL, 8'h00);
    wr_reg(3'h6, 8'hA5);
    rd_chk("unmapped", 3'h6, 8'h00);
    wr_reg(GSTMR_ADDR_HIGH, 8'hAB);
    wr_reg(GSTMR_ADDR_LOW, 8'hCD);
    @(negedge mclk);
    chk("load", count, 16'hABCD);
    delta(40);
    chk("off", d, 16'h0000);
    // Every prescale ratio over forty instruction ticks
    for (int p = 0; p < 4; p++) begin
      cfg({2'b00, p[1:0], 4'h1}, 8'h00, GSTMR_CS_INSTR);
      delta(160);
      chk("prescale", d, 16'(40 >> p));
    end
    cfg(8'h01, 8'h00, GSTMR_CS_OSC);
    delta(40);
    chk("osc", d, 16'h0028);
    // Gate: each source, polarity and level
    cfg(8'h01, 8'h00, GSTMR_CS_INSTR);
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 4; k++) begin
        i_pin.set_gate(s, k[0]);
        wr_reg(GSTMR_ADDR_GATE, {1'b1, k[1], 4'h0, s[1:0]});
        repeat (4) @(negedge mclk);
        delta(16);
        chk("gate", d, k[0] == k[1] ? 16'h4 : 16'h0);
      end
    end
    // Rollover, timer stopped before the count is written
    cfg(8'h00, 8'h00, GSTMR_CS_INSTR);
    wr_reg(GSTMR_ADDR_HIGH, 8'hFF);
    wr_reg(GSTMR_ADDR_LOW, 8'hFE);
    @(negedge mclk);
    chk("preload", count, 16'hFFFE);
    chk("no flag", {15'h0000, overflow_flag}, 16'h0000);
    wr_reg(GSTMR_ADDR_CTRL, 8'h01);
    repeat (16) @(negedge mclk);
    chk("flag", {15'h0000, overflow_flag}, 16'h0001);
    wr_reg(GSTMR_ADDR_CTRL, 8'h00);
    rd_chk("flag rd", GSTMR_ADDR_FLAG, 8'h01);
    wr_reg(GSTMR_ADDR_FLAG, 8'h00);
    rd_chk("flag clr", GSTMR_ADDR_FLAG, 8'h00);
    // Wide mode: high byte waits in the buffer
    wr_reg(GSTMR_ADDR_CTRL, 8'h02);
    prev = count;
    wr_reg(GSTMR_ADDR_HIGH, 8'h12);
    @(negedge mclk);
    chk("buffered", count, prev);
    wr_reg(GSTMR_ADDR_LOW, 8'h34);
    @(negedge mclk);
    chk("wide load", count, 16'h1234);
    // A stale buffer value must give way to the low read's snapshot
    wr_reg(GSTMR_ADDR_HIGH, 8'h56);
    rd_chk("wide low", GSTMR_ADDR_LOW, 8'h34);
    rd_chk("wide high", GSTMR_ADDR_HIGH, 8'h12);
    // Pin counting: first rise after a write is not counted
    cfg(8'h00, 8'h00, GSTMR_CS_EXT);
    wr_reg(GSTMR_ADDR_HIGH, 8'h00);
    wr_reg(GSTMR_ADDR_LOW, 8'h00);
    wr_reg(GSTMR_ADDR_CTRL, 8'h01);
    i_pin.pulses(6);
    repeat (8) @(negedge mclk);
    chk("ext sync", count, 16'h0005);
    wr_reg(GSTMR_ADDR_CTRL, 8'h00);
    wr_reg(GSTMR_ADDR_LOW, 8'h00);
    sleep <= 1'b1;
    wr_reg(GSTMR_ADDR_CTRL, 8'h05);
    i_pin.pulses(6);
    repeat (8) @(negedge mclk);
    chk("ext async", count, 16'h0005);
    // Internal source stands still while asleep
    cfg(8'h01, 8'h00, GSTMR_CS_INSTR);
    delta(40);
    chk("sleep halt", d, 16'h0000);
    @(posedge mclk);
    sleep <= 1'b0;
    // The spare source code counts nothing
    cfg(8'h01, 8'h00, 2'h3);
    delta(40);
    chk("no source", d, 16'h0000);
    close_out();
  end
endmodule // gstmr_tb_top
